/* File: src/wpu_pkg.sv */
package wpu_pkg;

	localparam int NUM_WP    = 4;
	localparam int NUM_THR   = 8;
	localparam int THR_W     = 3;
	localparam int ADDR_W    = 10;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_DADDR_A  = 8'h50;
	localparam logic [7:0] IDX_DADDR_B  = 8'h60;
	localparam logic [7:0] IDX_DCTL     = 8'h70;
	localparam logic [7:0] IDX_RMASK    = 8'h80;
	localparam logic [7:0] IDX_RVALUE   = 8'h90;
	localparam logic [7:0] IDX_RCTL     = 8'h9C;
	localparam logic [7:0] IDX_IRQ_TYPE = 8'h15;
	localparam logic [7:0] IDX_IRQ_DATA = 8'h16;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h17;

	// Control word fields
	localparam int CTL_THR_LSB  = 16;
	localparam int CTL_THR_MSB  = 23;
	localparam int CTL_LOAD_BIT = 2;
	localparam int CTL_MODE_BIT = 1;
	localparam int CTL_EN_BIT   = 0;

	// Interrupt type fields
	localparam int TYPE_NUM_LSB   = 16;
	localparam int TYPE_NUM_MSB   = 17;
	localparam int TYPE_THR_LSB   = 8;
	localparam int TYPE_THR_MSB   = 15;
	localparam int TYPE_CAUSE_MSB = 2;
	localparam int STAT_PEND_BIT  = 0;

	localparam logic [2:0]  CAUSE_NONE   = 3'h0;
	localparam logic [2:0]  CAUSE_DATA   = 3'h4;
	localparam logic [2:0]  CAUSE_RES    = 3'h5;
	localparam logic [31:0] RST_WORD     = 32'h0000_0000;
	localparam logic [7:0]  RST_THREADS  = 8'h00;

	typedef struct packed {
		logic [NUM_THR-1:0] threads;
		logic               load;
		logic               either;
		logic               en;
	} wpu_dctl_t;

	typedef struct packed {
		logic [NUM_THR-1:0] threads;
		logic               cond_b;
		logic               en;
	} wpu_rctl_t;

	typedef struct packed {
		logic             valid;
		logic             load;
		logic [THR_W-1:0] thread;
		logic [31:0]      addr;
	} wpu_mem_op_t;

	typedef struct packed {
		logic             valid;
		logic [THR_W-1:0] thread;
		logic [31:0]      rid;
	} wpu_res_op_t;

	typedef struct packed {
		logic             we;
		logic             re;
		logic [ADDR_W-1:0] addr;
		logic [31:0]      wdata;
	} wpu_bus_req_t;

	typedef struct packed {
		logic [NUM_WP-1:0][31:0] addr_a;
		logic [NUM_WP-1:0][31:0] addr_b;
		wpu_dctl_t [NUM_WP-1:0]  dctl;
		logic [NUM_WP-1:0][31:0] rmask;
		logic [NUM_WP-1:0][31:0] rvalue;
		wpu_rctl_t [NUM_WP-1:0]  rctl;
		logic [2:0]              cause;
		logic [1:0]              wp_num;
		logic [7:0]              thread;
		logic [31:0]             data;
		logic                    pending;
		logic [31:0]             rdata;
	} wpu_state_t;

endpackage : wpu_pkg

/* File: src/wpu_data_match.sv */
`timescale 1ns/1ps

module wpu_data_match #(
	parameter int NUM = 4
) (
	input  wire logic [NUM-1:0][31:0]        i_addr_a,
	input  wire logic [NUM-1:0][31:0]        i_addr_b,
	input  wpu_pkg::wpu_dctl_t [NUM-1:0]     i_ctl,
	input  wpu_pkg::wpu_mem_op_t             i_op,
	output logic [NUM-1:0]                   o_hit
);

	always_comb begin
		logic cond_a;
		logic cond_b;
		logic kind_ok;
		cond_a  = 1'b0;
		cond_b  = 1'b0;
		kind_ok = 1'b0;
		for (int i = 0; i < NUM; i++) begin
			// A: at or above first address, B: at or below second
			cond_a  = i_op.addr >= i_addr_a[i];
			cond_b  = i_op.addr <= i_addr_b[i];
			kind_ok = i_ctl[i].load ? i_op.load : !i_op.load;
			o_hit[i] = i_op.valid && i_ctl[i].en
				&& i_ctl[i].threads[i_op.thread]
				&& kind_ok
				&& (i_ctl[i].either ? (cond_a || cond_b) : (cond_a && cond_b));
		end
	end

endmodule : wpu_data_match

/* File: src/wpu_res_match.sv */
`timescale 1ns/1ps

module wpu_res_match #(
	parameter int NUM = 4
) (
	input  wire logic [NUM-1:0][31:0]        i_mask,
	input  wire logic [NUM-1:0][31:0]        i_value,
	input  wpu_pkg::wpu_rctl_t [NUM-1:0]     i_ctl,
	input  wpu_pkg::wpu_res_op_t             i_op,
	output logic [NUM-1:0]                   o_hit
);

	always_comb begin
		logic equal;
		equal = 1'b0;
		for (int i = 0; i < NUM; i++) begin
			equal = (i_op.rid & i_mask[i]) == i_value[i];
			o_hit[i] = i_op.valid && i_ctl[i].en
				&& i_ctl[i].threads[i_op.thread]
				&& (i_ctl[i].cond_b ? !equal : equal);
		end
	end

endmodule : wpu_res_match

/* File: src/wpu_top.sv */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

//
// Contract
// - Four 32-bit first-address registers from index 0x50, one per data watch.
// - Four 32-bit second-address registers from index 0x60, one per data watch.
// - Four data control words from index 0x70; bits 31:24 and 15:3 reserved.
// - Data control bits 23:16 are a per-thread enable mask, reset zero.
// - Data control bit 2 set makes the watch trigger on loads; resets zero.
// - Data control bit 1: zero needs A and B, one needs A or B.
// - Data control bit 0 enables the data watch; resets zero.
// - Four 32-bit resource mask registers from index 0x80.
// - Four 32-bit resource value registers from index 0x90.
// - Four resource control words from index 0x9C; bits 31:24, 15:2 reserved.
// - Resource control bits 23:16 are a per-thread enable mask, reset zero.
// - Resource control bit 1: zero breaks on A, one breaks on B.
// - Resource control bit 0 enables the resource watch; resets zero.
// - A hit raises the debug interrupt; cause 4 for data, 5 for resource.
// - Data hit captures effective address; resource hit captures resource id.
// - Triggering watch number kept in two bits; any data hit wins over a resource hit, then lowest number wins.
// - Number of the triggering thread kept in an eight-bit field.
module wpu_top #(
	parameter int NUM_WP = wpu_pkg::NUM_WP
) (
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_rst,
	input  wire logic [wpu_pkg::ADDR_W-1:0]  i_addr,
	input  wire logic [31:0]                 i_wdata,
	input  wire logic                        i_we,
	input  wire logic                        i_re,
	output logic [31:0]                      o_rdata,
	input  wpu_pkg::wpu_mem_op_t             i_mem_op,
	input  wpu_pkg::wpu_res_op_t             i_res_op,
	output logic                             o_dbg_irq
);

	wpu_pkg::wpu_state_t          s_q;
	wpu_pkg::wpu_state_t          s_d;
	logic [wpu_pkg::NUM_WP-1:0]   dhit;
	logic [wpu_pkg::NUM_WP-1:0]   rhit;

	// Index falls within a group of four consecutive registers
	function automatic logic in_group(input logic [7:0] idx, input logic [7:0] base);
		logic [7:0] top;
		top = base + 8'h03;
		return (idx >= base) && (idx <= top);
	endfunction : in_group

	// Lowest set bit of a hit vector
	function automatic logic [1:0] lowest(input logic [wpu_pkg::NUM_WP-1:0] v);
		logic [1:0] n;
		logic       found;
		n     = 2'h0;
		found = 1'b0;
		for (int i = 0; i < wpu_pkg::NUM_WP; i++) begin
			if (v[i] && !found) begin
				n     = i[1:0];
				found = 1'b1;
			end
		end
		return n;
	endfunction : lowest

	function automatic logic [31:0] dctl_word(input wpu_pkg::wpu_dctl_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[wpu_pkg::CTL_THR_MSB:wpu_pkg::CTL_THR_LSB] = c.threads;
		w[wpu_pkg::CTL_LOAD_BIT] = c.load;
		w[wpu_pkg::CTL_MODE_BIT] = c.either;
		w[wpu_pkg::CTL_EN_BIT]   = c.en;
		return w;
	endfunction : dctl_word

	function automatic logic [31:0] rctl_word(input wpu_pkg::wpu_rctl_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[wpu_pkg::CTL_THR_MSB:wpu_pkg::CTL_THR_LSB] = c.threads;
		w[wpu_pkg::CTL_MODE_BIT] = c.cond_b;
		w[wpu_pkg::CTL_EN_BIT]   = c.en;
		return w;
	endfunction : rctl_word

	wpu_data_match #(
		.NUM      (wpu_pkg::NUM_WP)
	) u_data (
		.i_addr_a (s_q.addr_a),
		.i_addr_b (s_q.addr_b),
		.i_ctl    (s_q.dctl),
		.i_op     (i_mem_op),
		.o_hit    (dhit)
	);

	wpu_res_match #(
		.NUM      (wpu_pkg::NUM_WP)
	) u_res (
		.i_mask   (s_q.rmask),
		.i_value  (s_q.rvalue),
		.i_ctl    (s_q.rctl),
		.i_op     (i_res_op),
		.o_hit    (rhit)
	);

	always_comb begin
		logic [7:0] idx;
		logic       aligned;
		logic [1:0] k;
		logic       clr;
		s_d      = s_q;
		s_d.rdata = 32'h0000_0000;
		idx      = i_addr[9:2];
		aligned  = i_addr[1:0] == 2'h0;
		k        = idx[1:0];
		clr      = 1'b0;

		if (i_we && aligned) begin
			if (in_group(idx, wpu_pkg::IDX_DADDR_A)) begin
				s_d.addr_a[k] = i_wdata;
			end else if (in_group(idx, wpu_pkg::IDX_DADDR_B)) begin
				s_d.addr_b[k] = i_wdata;
			end else if (in_group(idx, wpu_pkg::IDX_DCTL)) begin
				// Only defined bits are stored
				s_d.dctl[k].threads = i_wdata[wpu_pkg::CTL_THR_MSB:wpu_pkg::CTL_THR_LSB];
				s_d.dctl[k].load    = i_wdata[wpu_pkg::CTL_LOAD_BIT];
				s_d.dctl[k].either  = i_wdata[wpu_pkg::CTL_MODE_BIT];
				s_d.dctl[k].en      = i_wdata[wpu_pkg::CTL_EN_BIT];
			end else if (in_group(idx, wpu_pkg::IDX_RMASK)) begin
				s_d.rmask[k] = i_wdata;
			end else if (in_group(idx, wpu_pkg::IDX_RVALUE)) begin
				s_d.rvalue[k] = i_wdata;
			end else if (in_group(idx, wpu_pkg::IDX_RCTL)) begin
				s_d.rctl[k].threads = i_wdata[wpu_pkg::CTL_THR_MSB:wpu_pkg::CTL_THR_LSB];
				s_d.rctl[k].cond_b  = i_wdata[wpu_pkg::CTL_MODE_BIT];
				s_d.rctl[k].en      = i_wdata[wpu_pkg::CTL_EN_BIT];
			end else if (idx == wpu_pkg::IDX_IRQ_TYPE) begin
				s_d.wp_num = i_wdata[wpu_pkg::TYPE_NUM_MSB:wpu_pkg::TYPE_NUM_LSB];
				s_d.thread = i_wdata[wpu_pkg::TYPE_THR_MSB:wpu_pkg::TYPE_THR_LSB];
				s_d.cause  = i_wdata[wpu_pkg::TYPE_CAUSE_MSB:0];
			end else if (idx == wpu_pkg::IDX_IRQ_DATA) begin
				s_d.data = i_wdata;
			end else if (idx == wpu_pkg::IDX_IRQ_STAT) begin
				clr = i_wdata[wpu_pkg::STAT_PEND_BIT];
			end
		end

		if (i_re && aligned) begin
			if (in_group(idx, wpu_pkg::IDX_DADDR_A)) begin
				s_d.rdata = s_q.addr_a[k];
			end else if (in_group(idx, wpu_pkg::IDX_DADDR_B)) begin
				s_d.rdata = s_q.addr_b[k];
			end else if (in_group(idx, wpu_pkg::IDX_DCTL)) begin
				s_d.rdata = dctl_word(s_q.dctl[k]);
			end else if (in_group(idx, wpu_pkg::IDX_RMASK)) begin
				s_d.rdata = s_q.rmask[k];
			end else if (in_group(idx, wpu_pkg::IDX_RVALUE)) begin
				s_d.rdata = s_q.rvalue[k];
			end else if (in_group(idx, wpu_pkg::IDX_RCTL)) begin
				s_d.rdata = rctl_word(s_q.rctl[k]);
			end else if (idx == wpu_pkg::IDX_IRQ_TYPE) begin
				s_d.rdata[wpu_pkg::TYPE_NUM_MSB:wpu_pkg::TYPE_NUM_LSB] = s_q.wp_num;
				s_d.rdata[wpu_pkg::TYPE_THR_MSB:wpu_pkg::TYPE_THR_LSB] = s_q.thread;
				s_d.rdata[wpu_pkg::TYPE_CAUSE_MSB:0] = s_q.cause;
			end else if (idx == wpu_pkg::IDX_IRQ_DATA) begin
				s_d.rdata = s_q.data;
			end else if (idx == wpu_pkg::IDX_IRQ_STAT) begin
				s_d.rdata[wpu_pkg::STAT_PEND_BIT] = s_q.pending;
			end
		end

		if (clr) begin
			s_d.pending = 1'b0;
		end

		// First hit is held until software clears pending; a hit wins over a clear
		if ((|dhit || |rhit) && (!s_q.pending || clr)) begin
			s_d.pending = 1'b1;
			if (|dhit) begin
				s_d.cause  = wpu_pkg::CAUSE_DATA;
				s_d.wp_num = lowest(dhit);
				s_d.thread = {5'h00, i_mem_op.thread};
				s_d.data   = i_mem_op.addr;
			end else begin
				s_d.cause  = wpu_pkg::CAUSE_RES;
				s_d.wp_num = lowest(rhit);
				s_d.thread = {5'h00, i_res_op.thread};
				s_d.data   = i_res_op.rid;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
			for (int i = 0; i < wpu_pkg::NUM_WP; i++) begin
				s_q.dctl[i].threads <= wpu_pkg::RST_THREADS;
				s_q.rctl[i].threads <= wpu_pkg::RST_THREADS;
				s_q.addr_a[i]       <= wpu_pkg::RST_WORD;
			end
			s_q.cause <= wpu_pkg::CAUSE_NONE;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata   = s_q.rdata;
	assign o_dbg_irq = s_q.pending;

endmodule : wpu_top

/* File: tb/wpu_properties.sv */
`timescale 1ns/1ps
module wpu_properties (
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_rst,
	input  wire logic [wpu_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [31:0]                i_wdata,
	input  wire logic                       i_we,
	input  wire logic                       i_re,
	input  wire logic [31:0]                o_rdata,
	input  wpu_pkg::wpu_mem_op_t            i_mem_op,
	input  wpu_pkg::wpu_res_op_t            i_res_op,
	input  wire logic                       o_dbg_irq
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	logic irq_q;
	logic sw_type_q;
	// Type word last written by software rather than by a capture
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_q     <= 1'b0;
			sw_type_q <= 1'b0;
		end else begin
			irq_q <= o_dbg_irq;
			if (i_we && i_addr == 10'h054) begin
				sw_type_q <= 1'b1;
			end else if (o_dbg_irq && !irq_q) begin
				sw_type_q <= 1'b0;
			end
		end
	end
	// Write to a plain 32-bit address, mask or value word
	sequence s_wr_rw;
		i_we && i_addr[1:0] == 2'h0 && i_addr[5:4] == 2'h0
			&& i_addr[9:6] inside {4'h5, 4'h6, 4'h8, 4'h9};
	endsequence
	sequence s_rd_same;
		i_re && i_addr == $past(i_addr, 2);
	endsequence
	AST_RAW: assert property (s_wr_rw ##2 s_rd_same
		|=> o_rdata == $past(i_wdata, 3))
		else $error("read back differs from write");
	AST_IDLE: assert property (!i_re || i_addr == 10'h000 |=> o_rdata == 32'h0)
		else $error("read data not zero");
	AST_DCTL_RSV: assert property (i_re && i_addr[9:4] == 6'h1C
		|=> (o_rdata & 32'hFF00_FFF8) == 32'h0)
		else $error("data control reserved bits set");
	AST_RCTL_RSV: assert property (i_re && i_addr[9:4] == 6'h27
		|=> (o_rdata & 32'hFF00_FFFC) == 32'h0)
		else $error("resource control reserved bits set");
	AST_CAUSE: assert property (i_re && i_addr == 10'h054 && !sw_type_q
		|=> o_rdata[2:0] inside {3'h0, 3'h4, 3'h5})
		else $error("bad cause code");
	AST_IRQ_SRC: assert property ($rose(o_dbg_irq)
		|-> $past(i_mem_op.valid || i_res_op.valid))
		else $error("interrupt without operation");
	AST_IRQ_HOLD: assert property (o_dbg_irq && !(i_we && i_addr == 10'h05C) |=> o_dbg_irq)
		else $error("interrupt dropped");
	AST_IRQ_CLR: assert property (i_we && i_addr == 10'h05C && i_wdata[0]
		&& !i_mem_op.valid && !i_res_op.valid |=> !o_dbg_irq)
		else $error("interrupt not cleared");
endmodule : wpu_properties
bind wpu_top wpu_properties props_u (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_we, .i_re,
	.o_rdata, .i_mem_op, .i_res_op, .o_dbg_irq);

/* File: tb/wpu_core_model.sv */
`timescale 1ns/1ps
module wpu_core_model (
	input  wire logic            i_ref_clk,
	output wpu_pkg::wpu_mem_op_t o_mem_op,
	output wpu_pkg::wpu_res_op_t o_res_op
);
	initial begin
		o_mem_op = '0;
		o_res_op = '0;
	end
	// One cycle of operations, then idle with scrambled fields
	task automatic issue(input wpu_pkg::wpu_mem_op_t m, input wpu_pkg::wpu_res_op_t r);
		@(posedge i_ref_clk);
		o_mem_op <= m;
		o_res_op <= r;
		@(posedge i_ref_clk);
		o_mem_op <= {1'b0, ~m[35:0]};
		o_res_op <= {1'b0, ~r[34:0]};
	endtask : issue
endmodule : wpu_core_model

/* File: tb/wpu_top_tb.sv */
`timescale 1ns/1ps
module wpu_top_tb;
	logic                 ref_clk = 1'b0;
	logic                 rst;
	logic [9:0]           addr;
	logic [31:0]          wdata;
	logic                 we;
	logic                 re;
	logic [31:0]          rdata;
	logic                 irq;
	logic                 pend;
	logic [31:0]          x = 32'h0000_CFAB;
	logic [31:0]          rf [0:255];
	wpu_pkg::wpu_mem_op_t mem_op;
	wpu_pkg::wpu_res_op_t res_op;
	int                   failures = 0;
	int                   samples_checked = 0;
	always #2 ref_clk = ~ref_clk;
	wpu_top dut_u (.i_ref_clk(ref_clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_we(we), .i_re(re), .o_rdata(rdata), .i_mem_op(mem_op), .i_res_op(res_op),
		.o_dbg_irq(irq));
	wpu_core_model core_u (.i_ref_clk(ref_clk), .o_mem_op(mem_op), .o_res_op(res_op));
	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : rnd
	task automatic tally_and_finish();
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] idx);
		@(posedge ref_clk);
		re <= 1'b1;
		addr <= {idx, 2'h0};
		@(posedge ref_clk);
		re <= 1'b0;
		#1 chk(rdata, rf[idx]);
	endtask : rd
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input bit back);
		@(posedge ref_clk);
		we <= 1'b1;
		addr <= {idx, 2'h0};
		wdata <= d;
		@(posedge ref_clk);
		we <= 1'b0;
		if (idx inside {[8'h70:8'h73]}) d &= 32'h00FF_0007;
		if (idx >= 8'h9C) d &= 32'h00FF_0003;
		if (idx == 8'h15) d &= 32'h0003_FF07;
		if (idx != 8'h17) rf[idx] = d;
		if (back) rd(idx);
	endtask : wr
	task automatic rd_reset();
		for (int i = 0; i < 4; i++) begin
			rd(8'h50 + i);
			rd(8'h70 + i);
			rd(8'h9C + i);
		end
		rd(8'h15);
	endtask : rd_reset
	function automatic void step(input wpu_pkg::wpu_mem_op_t m, input wpu_pkg::wpu_res_op_t r);
		logic [2:0]  cause;
		logic [1:0]  num;
		logic [2:0]  t;
		logic [31:0] c;
		logic [31:0] d;
		logic        a;
		logic        b;
		cause = 3'h0;
		for (int w = 3; w >= 0; w--) begin
			c = rf[8'h70 + w];
			a = m.addr >= rf[8'h50 + w];
			b = m.addr <= rf[8'h60 + w];
			if (m.valid && c[0] && c[16 + m.thread] && c[2] == m.load
				&& (c[1] ? a | b : a & b)) begin
				cause = 3'h4;
				num = w[1:0];
				t = m.thread;
				d = m.addr;
			end
		end
		for (int w = 3; w >= 0; w--) begin
			c = rf[8'h9C + w];
			if (cause != 3'h4 && r.valid && c[0] && c[16 + r.thread]
				&& (((r.rid & rf[8'h80 + w]) != rf[8'h90 + w]) == c[1])) begin
				cause = 3'h5;
				num = w[1:0];
				t = r.thread;
				d = r.rid;
			end
		end
		if (cause != 3'h0 && !pend) begin
			pend = 1'b1;
			rf[8'h15] = {14'h0, num, 5'h0, t, 5'h0, cause};
			rf[8'h16] = d;
		end
	endfunction : step
	initial begin
		wpu_pkg::wpu_mem_op_t m;
		wpu_pkg::wpu_res_op_t r;
		logic [31:0]          v;
		rst = 1'b1;
		we = 1'b0;
		re = 1'b0;
		addr = 10'h000;
		wdata = 32'h0;
		pend = 1'b0;
		for (int i = 0; i < 256; i++) rf[i] = 32'h0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		rd_reset();
		rd(8'h00);
		wr(8'h15, rnd(), 1'b1);
		wr(8'h16, rnd(), 1'b1);
		for (int n = 0; n < 80; n++) begin
			for (int w = 0; w < 4; w++) begin
				wr(8'h50 + w, rnd() & 32'hFF, n < 3);
				wr(8'h60 + w, rnd() & 32'hFF, n < 3);
				wr(8'h70 + w, rnd(), n < 3);
				wr(8'h80 + w, rnd() & 32'h3, n < 3);
				wr(8'h90 + w, rnd() & 32'h3, n < 3);
				wr(8'h9C + w, rnd(), n < 3);
			end
			for (int k = 0; k < 2; k++) begin
				v = rnd();
				m = {v[0] | v[1], v[2], v[5:3], rnd() & 32'hFF};
				r = {v[6] | v[7], v[10:8], rnd() & 32'h3};
				core_u.issue(m, r);
				step(m, r);
				#1 chk({31'h0, irq}, {31'h0, pend});
			end
			rd(8'h15);
			rd(8'h16);
			wr(8'h17, 32'h1, 1'b0);
			pend = 1'b0;
			// Reset in mid-run brings every register back to zero
			if (n == 40) begin
				rst <= 1'b1;
				repeat (2) @(posedge ref_clk);
				rst <= 1'b0;
				for (int i = 0; i < 256; i++) rf[i] = 32'h0;
				#1 chk({31'h0, irq}, 32'h0);
				rd_reset();
			end
		end
		tally_and_finish();
	end
	initial begin
		#200000;
		failures++;
		tally_and_finish();
	end
endmodule : wpu_top_tb
